// ---- rtl/emb_pkg.sv ----
/*
 * Package for the external memory bus interface: request kinds, the request
 * carrier, reset values and the fixed program memory layout constants.
 * Assumes a single 50 MHz core clock shared by every user of this package.
 */
package emb_pkg;

   // Fixed program memory layout.
   localparam logic [15:0] EMB_RESET_PC = 16'h0000;
   localparam logic [15:0] EMB_VEC_BASE = 16'h0003;
   localparam int EMB_VEC_STEP_LSB = 3;

   // Stretch field: width and value after reset.
   localparam int EMB_STRETCH_W = 3;
   localparam logic [2:0] EMB_STRETCH_RST = 3'h1;

   // Smallest write strobe width in clock cycles.
   localparam logic [3:0] EMB_WR_MIN = 4'h1;

   // Kinds of access that the core may ask for.
   typedef enum logic [2:0] {
      EMB_REQ_FETCH,
      EMB_REQ_CODE_READ,
      EMB_REQ_VECTOR,
      EMB_REQ_XREAD,
      EMB_REQ_XWRITE,
      EMB_REQ_DBG_WRITE
   } emb_kind_t;

   // One access request from the core.
   typedef struct packed {
      emb_kind_t kind;
      logic [15:0] addr;
      logic use_ri;
      logic [7:0] ri;
      logic [2:0] vec_idx;
      logic [7:0] wdata;
   } emb_req_t;

endpackage

// ---- rtl/emb_bus_if.sv ----
/*
 * External memory bus interface of an 8-bit controller core: program fetch,
 * code reads, interrupt vector fetch, external data reads and writes with a
 * programmable stretch, and the debug program write path.
 * Assumes the core and the memories share clk; acknowledges arrive
 * synchronously, and the core holds a request until it is taken.
 */
`timescale 1ns/1ps
module emb_bus_if
   import emb_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic stretch_we,
   input wire logic [7:0] stretch_wdata,
   input wire logic dbg_mode,
   input wire logic req_valid,
   input wire emb_req_t req,
   input wire logic mem_ps_ack,
   input wire logic [7:0] mem_din,
   output logic req_ready,
   output logic done,
   output logic [7:0] rdata,
   output logic [2:0] stretch,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_dout,
   output logic mem_ps_rd,
   output logic mem_rd,
   output logic mem_wr,
   output logic dbg_ps_wr,
   output logic movx
);

   typedef enum logic [2:0] {
      EMB_ST_IDLE,
      EMB_ST_FETCH,
      EMB_ST_DREAD,
      EMB_ST_DWRITE,
      EMB_ST_DBGWR
   } emb_state_t;

   emb_state_t state_ff;
   logic boot_ff;
   logic [2:0] stretch_ff;
   logic [3:0] ph_ff;
   logic [3:0] nxt_ph;
   logic [3:0] cur_n_ff;
   logic [3:0] wr_len;
   logic [15:0] addr_ff;
   logic [7:0] dout_ff;
   logic [7:0] rdata_ff;
   logic ps_rd_ff;
   logic rd_ff;
   logic wr_ff;
   logic dbg_wr_ff;
   logic movx_ff;
   logic done_ff;
   logic ready_ff;
   logic take;
   logic [15:0] req_addr;

   // The stretch field is the low three bits of the clock control byte.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         stretch_ff <= EMB_STRETCH_RST;
      else if (stretch_we)
         stretch_ff <= stretch_wdata[EMB_STRETCH_W-1:0];
   end

   assign take = req_valid && ready_ff;
   assign nxt_ph = ph_ff + 4'h1;
   // The write strobe never shrinks below one cycle, even with no stretch.
   assign wr_len = (cur_n_ff == 4'h0) ? EMB_WR_MIN : cur_n_ff;

   // Address formation for each request kind.
   always_comb
   begin
      case (req.kind)
         EMB_REQ_VECTOR:
            req_addr = EMB_VEC_BASE + (16'(req.vec_idx) << EMB_VEC_STEP_LSB);
         EMB_REQ_XREAD, EMB_REQ_XWRITE:
            req_addr = req.use_ri ? {8'h00, req.ri} : req.addr;
         default:
            req_addr = req.addr;
      endcase
   end

   // Sequencer: one access at a time, every width a whole number of cycles.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= EMB_ST_IDLE;
         boot_ff <= 1'b1;
         ph_ff <= 4'h0;
         cur_n_ff <= 4'h0;
         addr_ff <= 16'h0000;
         dout_ff <= 8'h00;
         ps_rd_ff <= 1'b0;
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         dbg_wr_ff <= 1'b0;
         movx_ff <= 1'b0;
         done_ff <= 1'b0;
         ready_ff <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         case (state_ff)
            EMB_ST_IDLE:
            begin
               ph_ff <= 4'h0;
               cur_n_ff <= {1'b0, stretch_ff};
               if (boot_ff)
               begin
                  // Core requests are held off until the reset fetch is out.
                  boot_ff <= 1'b0;
                  addr_ff <= EMB_RESET_PC;
                  ps_rd_ff <= 1'b1;
                  state_ff <= EMB_ST_FETCH;
               end
               else if (take)
               begin
                  ready_ff <= 1'b0;
                  addr_ff <= req_addr;
                  case (req.kind)
                     EMB_REQ_XREAD:
                     begin
                        rd_ff <= 1'b1;
                        movx_ff <= 1'b1;
                        state_ff <= EMB_ST_DREAD;
                     end
                     EMB_REQ_XWRITE:
                     begin
                        dout_ff <= req.wdata;
                        movx_ff <= 1'b1;
                        state_ff <= EMB_ST_DWRITE;
                     end
                     EMB_REQ_DBG_WRITE:
                     begin
                        // Outside debug mode the request completes with no write.
                        dout_ff <= req.wdata;
                        dbg_wr_ff <= dbg_mode;
                        state_ff <= EMB_ST_DBGWR;
                     end
                     default:
                     begin
                        ps_rd_ff <= 1'b1;
                        state_ff <= EMB_ST_FETCH;
                     end
                  endcase
               end
               else
                  ready_ff <= 1'b1;
            end
            EMB_ST_FETCH:
            begin
               if (mem_ps_ack)
               begin
                  ps_rd_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= EMB_ST_IDLE;
               end
            end
            EMB_ST_DREAD:
            begin
               ph_ff <= nxt_ph;
               if (ph_ff == cur_n_ff)
               begin
                  rd_ff <= 1'b0;
                  movx_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= EMB_ST_IDLE;
               end
            end
            EMB_ST_DWRITE:
            begin
               ph_ff <= nxt_ph;
               // Strobe sits inside the address window with a cycle of setup.
               wr_ff <= (nxt_ph >= 4'h1) && (nxt_ph <= wr_len);
               if (ph_ff == cur_n_ff + 4'h1)
               begin
                  wr_ff <= 1'b0;
                  movx_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= EMB_ST_IDLE;
               end
            end
            EMB_ST_DBGWR:
            begin
               dbg_wr_ff <= 1'b0;
               done_ff <= 1'b1;
               state_ff <= EMB_ST_IDLE;
            end
            default:
               state_ff <= EMB_ST_IDLE;
         endcase
      end
   end

   // Read data is caught on the cycle an access completes.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_ff <= 8'h00;
      else if ((state_ff == EMB_ST_FETCH && mem_ps_ack) || (state_ff == EMB_ST_DREAD && ph_ff == cur_n_ff))
         rdata_ff <= mem_din;
   end

   assign req_ready = ready_ff;
   assign done = done_ff;
   assign rdata = rdata_ff;
   assign stretch = stretch_ff;
   assign mem_addr = addr_ff;
   assign mem_dout = dout_ff;
   assign mem_ps_rd = ps_rd_ff;
   assign mem_rd = rd_ff;
   assign mem_wr = wr_ff;
   assign dbg_ps_wr = dbg_wr_ff;
   assign movx = movx_ff;

   // Helper counters of strobe widths, read only by the checks below.
   logic [3:0] rd_cnt_ff;
   logic [3:0] wr_cnt_ff;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_cnt_ff <= 4'h0;
         wr_cnt_ff <= 4'h0;
      end
      else
      begin
         rd_cnt_ff <= rd_ff ? rd_cnt_ff + 4'h1 : 4'h0;
         wr_cnt_ff <= wr_ff ? wr_cnt_ff + 4'h1 : 4'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wr_take;
      take && req.kind == EMB_REQ_XWRITE && stretch_ff != 3'h0;
   endsequence
   sequence s_wr_setup;
      movx_ff && !wr_ff ##1 wr_ff;
   endsequence

   property p_no_overlap;
      !(rd_ff && wr_ff);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("read and write strobes together");

   property p_rd_width;
      $fell(rd_ff) |-> $past(rd_cnt_ff) == cur_n_ff;
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");

   property p_wr_width;
      $fell(wr_ff) |-> $past(wr_cnt_ff) + 4'h1 == wr_len;
   endproperty
   a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");

   property p_wr_seq;
      s_wr_take |=> s_wr_setup;
   endproperty
   a_wr_seq: assert property (p_wr_seq) else $error("write strobe not after one setup cycle");

   property p_ps_only_fetch;
      ps_rd_ff |-> state_ff == EMB_ST_FETCH && !rd_ff && !wr_ff;
   endproperty
   a_ps_only_fetch: assert property (p_ps_only_fetch) else $error("program read outside a fetch");

   property p_boot;
      $rose(ps_rd_ff) && $past(boot_ff) |-> mem_addr == EMB_RESET_PC;
   endproperty
   a_boot: assert property (p_boot) else $error("first fetch not at reset address");

   property p_vector;
      take && req.kind == EMB_REQ_VECTOR |=> mem_addr == 16'h0003 + {10'h000, $past(req.vec_idx), 3'h0};
   endproperty
   a_vector: assert property (p_vector) else $error("vector address wrong");

   property p_ri_high;
      take && req.use_ri && (req.kind == EMB_REQ_XREAD || req.kind == EMB_REQ_XWRITE)
         |=> mem_addr[15:8] == 8'h00 ##1 mem_addr[15:8] == 8'h00;
   endproperty
   a_ri_high: assert property (p_ri_high) else $error("indirect move high byte not zero");

   property p_dbg_wr;
      dbg_ps_wr |-> $past(dbg_mode);
   endproperty
   a_dbg_wr: assert property (p_dbg_wr) else $error("program write outside debug mode");

   property p_stretch_load;
      stretch_we |=> stretch_ff == $past(stretch_wdata[2:0]);
   endproperty
   a_stretch_load: assert property (p_stretch_load) else $error("stretch field not loaded");

endmodule

// ---- sim/emb_mem_model.sv ----
/*
 * Memory model at the far side of the bus: program store, data RAM.
 * Assumes registered strobes from the interface on the shared clk.
 */
`timescale 1ns/1ps
module emb_mem_model
(
   input wire logic clk,
   input wire logic [1:0] ack_wait,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_dout,
   input wire logic mem_ps_rd,
   input wire logic mem_rd,
   input wire logic mem_wr,
   output logic mem_ps_ack,
   output logic [7:0] mem_din
);
   logic [7:0] dmem [0:255];
   logic [1:0] wait_ff;
   logic [7:0] last_ff;

   // Acknowledge a code read after ack_wait extra cycles, for one cycle.
   always_ff @(posedge clk)
   begin
      mem_ps_ack <= mem_ps_rd && !mem_ps_ack && wait_ff == ack_wait;
      wait_ff <= (mem_ps_rd && !mem_ps_ack && wait_ff != ack_wait) ? wait_ff + 2'h1 : 2'h0;
   end

   // Only the low address byte decodes, so the RAM stays small.
   initial
   begin
      for (int i = 0; i < 256; i++)
         dmem[i] = 8'h00;
   end
   always @(posedge clk)
   begin
      if (mem_wr)
         dmem[mem_addr[7:0]] <= mem_dout;
      last_ff <= mem_din;
   end

   // Released data lines toggle so a stale byte is never read as good.
   always @*
   begin
      if (mem_ps_rd)
         mem_din = mem_addr[7:0] ^ mem_addr[15:8];
      else if (mem_rd)
         mem_din = dmem[mem_addr[7:0]];
      else
         mem_din = ~last_ff;
   end
endmodule

// ---- sim/ext_memory_bus_interface_test.sv ----
/*
 * Self-checking testbench of the external memory bus interface.
 * Assumes emb_pkg, emb_bus_if and emb_mem_model are compiled first.
 */
`timescale 1ns/1ps
module ext_memory_bus_interface_test
   import emb_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic stretch_we = 1'b0;
   logic [7:0] stretch_wdata = 8'h00;
   logic dbg_mode = 1'b0;
   logic req_valid = 1'b0;
   emb_req_t req = '0;
   logic [1:0] ack_wait = 2'h0;
   logic mem_ps_ack, req_ready, done, mem_ps_rd, mem_rd, mem_wr, dbg_ps_wr, movx;
   logic [7:0] mem_din, rdata, mem_dout;
   logic [2:0] stretch;
   logic [15:0] mem_addr, a_seen;
   int n_fail = 0;
   int checked = 0;
   int n_rd, n_wr, n_mv, n_ps, n_dbg;

   emb_bus_if uut (.clk(clk), .rstn(rstn), .stretch_we(stretch_we), .stretch_wdata(stretch_wdata),
      .dbg_mode(dbg_mode), .req_valid(req_valid), .req(req), .mem_ps_ack(mem_ps_ack), .mem_din(mem_din),
      .req_ready(req_ready), .done(done), .rdata(rdata), .stretch(stretch), .mem_addr(mem_addr),
      .mem_dout(mem_dout), .mem_ps_rd(mem_ps_rd), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .dbg_ps_wr(dbg_ps_wr), .movx(movx));
   emb_mem_model mem (.clk(clk), .ack_wait(ack_wait), .mem_addr(mem_addr), .mem_dout(mem_dout),
      .mem_ps_rd(mem_ps_rd), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_ps_ack(mem_ps_ack), .mem_din(mem_din));

   // Clock of 20 ns period.
   always #10 clk = ~clk;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Count strobe cycles until done; bounded so a lost done is caught.
   task watch;
      int i;
      {n_rd, n_wr, n_mv, n_ps, n_dbg} = '0;
      for (i = 0; i < 60 && done !== 1'b1; i++)
      begin
         n_rd += mem_rd;
         n_wr += mem_wr;
         n_mv += movx;
         n_ps += mem_ps_rd;
         n_dbg += dbg_ps_wr;
         if (mem_rd | mem_wr | movx | mem_ps_rd | dbg_ps_wr)
            a_seen = mem_addr;
         @(posedge clk);
         #1;
      end
      chk(done, 1'b1);
   endtask

   // Request is raised once req_ready is seen high or after 50 cycles without it, and held for one edge.
   task access(input emb_kind_t k, input logic [15:0] a, input logic ri_on, input logic [7:0] ri,
      input logic [2:0] v, input logic [7:0] wd);
      for (int i = 0; i < 50 && req_ready !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      req_valid = 1'b1;
      req = {k, a, ri_on, ri, v, wd};
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      watch();
   endtask

   task set_st(input logic [2:0] n);
      stretch_we = 1'b1;
      stretch_wdata = {5'h15, n};
      @(posedge clk);
      #1;
      stretch_we = 1'b0;
      chk(stretch, n);
   endtask

   // Every stretch value: widths of write and read cycles, read-back.
   task t_stretch;
      int m;
      for (int n = 0; n < 8; n++)
      begin
         m = (n == 0) ? 1 : n;
         set_st(n[2:0]);
         access(EMB_REQ_XWRITE, 16'hfff8 + n[15:0], 1'b0, 8'h00, 3'h0, 8'ha0 + n[7:0]);
         chk(n_wr, m);
         chk(n_mv, n + 2);
         chk(n_rd + n_ps, 0);
         chk(a_seen, 16'hfff8 + n[15:0]);
         chk(mem_dout, 8'ha0 + n[7:0]);
         access(EMB_REQ_XREAD, 16'hfff8 + n[15:0], 1'b0, 8'h00, 3'h0, 8'h00);
         chk(n_rd, n + 1);
         chk(n_wr, 0);
         chk(rdata, 8'ha0 + n[7:0]);
      end
   endtask

   // Register-indirect moves take the low byte from ri, ignore addr and zero the high byte.
   task t_indirect;
      set_st(3'h1);
      access(EMB_REQ_XWRITE, 16'hab12, 1'b1, 8'h5a, 3'h0, 8'h3c);
      chk(a_seen, 16'h005a);
      access(EMB_REQ_XREAD, 16'hab12, 1'b1, 8'h5a, 3'h0, 8'h00);
      chk(a_seen, 16'h005a);
      chk(rdata, 8'h3c);
   endtask

   // Slow program memory: top fetch, code read and all vectors.
   task t_code;
      ack_wait = 2'h2;
      access(EMB_REQ_FETCH, 16'hffff, 1'b0, 8'h00, 3'h0, 8'h00);
      chk(a_seen, 16'hffff);
      chk(rdata, 8'h00);
      chk(n_rd + n_wr, 0);
      access(EMB_REQ_CODE_READ, 16'h1234, 1'b0, 8'h00, 3'h0, 8'h00);
      chk(rdata, 8'h26);
      for (int i = 0; i < 8; i++)
      begin
         access(EMB_REQ_VECTOR, 16'h0000, 1'b0, 8'h00, i[2:0], 8'h00);
         chk(a_seen, 16'h0003 + 16'(8 * i));
      end
      ack_wait = 2'h0;
   endtask

   // Program writes happen only in debug mode.
   task t_debug;
      access(EMB_REQ_DBG_WRITE, 16'h0040, 1'b0, 8'h00, 3'h0, 8'h77);
      chk(n_dbg + n_wr, 0);
      dbg_mode = 1'b1;
      access(EMB_REQ_DBG_WRITE, 16'h0040, 1'b0, 8'h00, 3'h0, 8'h77);
      chk(n_dbg, 1);
      chk(n_wr, 0);
      chk(a_seen, 16'h0040);
      chk(mem_dout, 8'h77);
      dbg_mode = 1'b0;
   endtask

   // A reset in mid-run restores the stretch and repeats the boot fetch.
   task t_reset;
      set_st(3'h6);
      rstn = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk(stretch, 3'h1);
      chk({req_ready, mem_ps_rd, mem_rd, mem_wr}, 4'h0);
      rstn = 1'b1;
      watch();
      chk(a_seen, 16'h0000);
      chk(n_ps > 0, 1);
   endtask

   // Watchdog well beyond the expected run length.
   initial
   begin
      #400000;
      n_fail++;
      end_sim();
   end

   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      chk(stretch, 3'h1);
      chk({req_ready, mem_ps_rd, mem_rd, mem_wr}, 4'h0);
      rstn = 1'b1;
      watch();
      chk(a_seen, 16'h0000);
      chk(n_ps > 0, 1);
      t_stretch();
      t_indirect();
      t_code();
      t_debug();
      t_reset();
      end_sim();
   end
endmodule
